/* ipvu_unit.v */
// Purpose: Interrupt poll and vector unit with an APB register port.
// Assumes: The core reports final instruction cycles and exit instructions.
// Notes:   Machine cycle is 12 ref_clk periods, counted internally.
`include "ipvu_defs.vh"
`default_nettype none
module ipvu_unit (
    input  wire        ref_clk,          // Oscillator clock.
    input  wire        rst,              // Synchronous reset.
    input  wire        psel,             // APB select.
    input  wire        penable,          // APB enable.
    input  wire        pwrite,           // APB write.
    input  wire [7:0]  paddr,            // APB byte address.
    input  wire [31:0] pwdata,           // APB write data.
    output reg  [31:0] prdata,           // APB read data.
    output reg         pready,           // APB ready.
    output reg         pslverr,          // APB error.
    input  wire [6:0]  extReqPin,        // Ext request pins 0 to 6.
    input  wire        timer2TriggerPin, // Timer-2 trigger pin.
    input  wire        timer0OvfFlag,    // Timer-0 overflow flag.
    input  wire        timer1OvfFlag,    // Timer-1 overflow flag.
    input  wire        timer2OvfFlag,    // Timer-2 overflow flag.
    input  wire        uartRxDoneFlag,   // Serial receive flag.
    input  wire        uartTxDoneFlag,   // Serial transmit flag.
    input  wire        converterDoneFlag,// Converter done flag.
    input  wire        instrFinalCycle,  // Current cycle ends instruction.
    input  wire        instrBlockNext,   // Exit or enable/priority access.
    input  wire        intExitExec,      // Interrupt exit executed, pulse.
    output reg         mcStart,          // Machine cycle start pulse.
    output reg         vecCallStart,     // Vector call start pulse.
    output reg         vecCallBusy,      // Vector call in its two cycles.
    output reg  [15:0] vecAddr,          // Vector address of the call.
    output reg  [1:0]  timerFlagClr,     // Timer-0/1 flag clear pulses.
    output reg  [3:0]  levelInProgress   // In-progress level marks.
);
    // ========================================================
    // Vector lookup and priority group decode
    // ========================================================
    function [15:0] vecOf;
        input [3:0] idx;
        begin
            if (idx < `IPVU_SRC_ADC)
                vecOf = `IPVU_VEC_BASE + `IPVU_VEC_STEP * {12'h000, idx};
            else if (idx == `IPVU_SRC_ADC)
                vecOf = `IPVU_VEC_ADC;
            else
                vecOf = `IPVU_VEC_EXT2 + `IPVU_VEC_STEP * {12'h000, idx - 4'h7};
        end
    endfunction

    function [2:0] grpOf;
        input [3:0] idx;
        reg   [3:0] ofs;
        begin
            ofs = idx - `IPVU_SRC_ADC;
            if (idx < `IPVU_SRC_ADC)
                grpOf = idx[2:0];
            else
                grpOf = ofs[2:0];
        end
    endfunction

    // ========================================================
    // Registers and state
    // ========================================================
    localparam [2:0] CALL_IDLE = 3'h1;
    localparam [2:0] CALL_ONE  = 3'h2;
    localparam [2:0] CALL_TWO  = 3'h4;

    reg  [3:0]  mcCnt_r;
    reg  [7:0]  enA_r;
    reg  [7:0]  enB_r;
    reg  [7:0]  prioLo_r;
    reg  [7:0]  prioHi_r;
    reg  [7:0]  ctrl_r;
    reg  [7:0]  extFlag_r;
    reg  [7:0]  pinSample_r;
    reg         sampValid_r;
    reg  [11:0] sample_r;
    reg  [11:0] poll_r;
    reg  [2:0]  callSt_r;
    reg  [2:0]  callSt_nxt;
    reg  [3:0]  levelSet;
    reg  [3:0]  levelClr;
    reg  [3:0]  winIdx;
    reg  [1:0]  winLvl;
    reg         winHit;
    reg  [1:0]  lvl;
    reg  [2:0]  grp;
    reg  [2:0]  actTop;
    reg         finalCyc;
    reg         blocked;
    reg  [31:0] rdVal;
    reg         rdHit;
    integer     i;
    integer     j;
    wire [7:0]  pinSync;
    wire [11:0] reqVec;
    wire [11:0] enVec;
    wire        wrStb;
    wire        cycEnd;
    wire        doCall;
    wire        state5_phase2;
    wire        pinTick;
    wire [7:0]  swClr;

    ipvu_pin_sync i_ipvu_pin_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pinIn    ({timer2TriggerPin, extReqPin}),
        .pinOut_r (pinSync)
    );

    // ========================================================
    // Machine cycle timing
    // ========================================================
    assign cycEnd  = (mcCnt_r == `IPVU_MC_LAST);
    assign state5_phase2    = (mcCnt_r == `IPVU_STATE5_PH2);
    assign pinTick = (mcCnt_r == `IPVU_PIN_SAMPLE);

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            mcCnt_r <= 4'h0;
            mcStart <= 1'b0;
        end
        else
        begin
            mcCnt_r <= cycEnd ? 4'h0 : mcCnt_r + 4'h1;
            mcStart <= cycEnd;
        end
    end

    // ========================================================
    // External request flags
    // ========================================================
    // Bits 0..6 are ext0..ext6, bit 7 the timer-2 trigger flag.
    assign wrStb = psel & penable & pready & pwrite;
    assign swClr = (wrStb && paddr == `IPVU_OFS_FLAGS) ? pwdata[7:0] : 8'h00;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pinSample_r <= 8'h00;
            sampValid_r <= 1'b0;
        end
        else if (pinTick)
        begin
            pinSample_r <= pinSync;
            sampValid_r <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `IPVU_NPIN; g = g + 1)
        begin : gFlag
            wire fall = sampValid_r & pinSample_r[g] & ~pinSync[g];
            wire rise = sampValid_r & ~pinSample_r[g] & pinSync[g];
            reg  setEv;
            reg  levelMode;
            reg  hwClr;
            always @*
            begin
                levelMode = 1'b0;
                setEv = 1'b0;
                hwClr = 1'b0;
                if (g == 0 || g == 1)
                begin
                    levelMode = ~ctrl_r[g];
                    setEv = levelMode ? ~pinSync[g] : fall;
                    hwClr = ~levelMode;
                end
                else if (g == 2 || g == 3)
                begin
                    setEv = ctrl_r[g] ? rise : fall;
                    hwClr = 1'b1;
                end
                else if (g < 7)
                begin
                    setEv = rise;
                    hwClr = 1'b1;
                end
                else
                    setEv = fall & ctrl_r[`IPVU_CTRL_T2_TRIG];
            end

            always @(posedge ref_clk)
            begin
                if (rst)
                    extFlag_r[g] <= 1'b0;
                else if (pinTick && levelMode)
                    extFlag_r[g] <= setEv;
                else if (pinTick && setEv)
                    extFlag_r[g] <= 1'b1;
                else if (swClr[g] || (doCall && hwClr && winIdx == flagSrc(g)))
                    extFlag_r[g] <= 1'b0;
            end
        end
    endgenerate

    function [3:0] flagSrc;
        input integer n;
        begin
            if (n == 0)
                flagSrc = 4'h0;
            else if (n == 1)
                flagSrc = 4'h2;
            else if (n < 7)
                flagSrc = n[3:0] + 4'h5;
            else
                flagSrc = 4'hf;
        end
    endfunction

    // ========================================================
    // Request sampling and polling
    // ========================================================
    // Serial, timer-2 overflow and converter flags are only read here, never
    // cleared, so software must clear them at their source.
    assign reqVec = {extFlag_r[6:2],
                     converterDoneFlag,
                     timer2OvfFlag | extFlag_r[7],
                     uartRxDoneFlag | uartTxDoneFlag,
                     timer1OvfFlag,
                     extFlag_r[1],
                     timer0OvfFlag,
                     extFlag_r[0]};
    assign enVec  = {12{enA_r[`IPVU_GLOBAL_EN]}} & {enB_r[5:0], enA_r[5:0]};

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            sample_r <= 12'h000;
            poll_r   <= 12'h000;
        end
        else
        begin
            if (state5_phase2)
                sample_r <= reqVec & enVec;
            if (cycEnd)
                poll_r <= sample_r;
        end
    end

    // Highest level wins; ties go to the lowest source index.
    always @*
    begin
        winIdx = 4'h0;
        winLvl = 2'h0;
        winHit = 1'b0;
        lvl = 2'h0;
        grp = 3'h0;
        for (i = `IPVU_NSRC - 1; i >= 0; i = i - 1)
        begin
            grp = grpOf(i[3:0]);
            lvl = {prioHi_r[grp], prioLo_r[grp]};
            if (poll_r[i] && (!winHit || lvl >= winLvl))
            begin
                winHit = 1'b1;
                winLvl = lvl;
                winIdx = i[3:0];
            end
        end
    end

    // ========================================================
    // Blocking and vector call sequencing
    // ========================================================
    always @*
    begin
        actTop = 3'h0;
        for (j = 0; j < 4; j = j + 1)
            if (levelInProgress[j])
                actTop = j[2:0] + 3'h1;
        finalCyc = 1'b0;
        blocked  = 1'b0;
        case (callSt_r)
            CALL_IDLE:
            begin
                finalCyc = instrFinalCycle;
                blocked  = instrBlockNext;
            end
            CALL_TWO:
                finalCyc = 1'b1;
            default:
                finalCyc = 1'b0;
        endcase
        if (actTop > {1'b0, winLvl})
            blocked = 1'b1;
    end

    assign doCall = cycEnd & winHit & finalCyc & ~blocked;

    always @*
    begin
        callSt_nxt = callSt_r;
        if (cycEnd)
        begin
            case (callSt_r)
                CALL_IDLE: callSt_nxt = doCall ? CALL_ONE : CALL_IDLE;
                CALL_ONE:  callSt_nxt = CALL_TWO;
                CALL_TWO:  callSt_nxt = doCall ? CALL_ONE : CALL_IDLE;
                default:   callSt_nxt = CALL_IDLE;
            endcase
        end
    end

    always @*
    begin
        levelSet = 4'h0;
        levelClr = 4'h0;
        if (doCall)
            levelSet[winLvl] = 1'b1;
        if (intExitExec && actTop != 3'h0)
            levelClr[actTop[1:0] - 2'h1] = 1'b1;
    end

    // The call outputs only start the push; the status word is not saved.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            callSt_r        <= CALL_IDLE;
            vecCallStart    <= 1'b0;
            vecCallBusy     <= 1'b0;
            vecAddr         <= 16'h0000;
            timerFlagClr    <= 2'h0;
            levelInProgress <= 4'h0;
        end
        else
        begin
            callSt_r        <= callSt_nxt;
            vecCallStart    <= doCall;
            vecCallBusy     <= callSt_nxt != CALL_IDLE;
            if (doCall)
                vecAddr <= vecOf(winIdx);
            timerFlagClr[0] <= doCall && winIdx == 4'h1;
            timerFlagClr[1] <= doCall && winIdx == 4'h3;
            levelInProgress <= (levelInProgress & ~levelClr) | levelSet;
        end
    end

    // ========================================================
    // APB register port
    // ========================================================
    always @*
    begin
        rdVal = 32'h0000_0000;
        rdHit = 1'b1;
        if (paddr == `IPVU_OFS_ENA)
            rdVal[7:0] = enA_r;
        else if (paddr == `IPVU_OFS_ENB)
            rdVal[7:0] = enB_r;
        else if (paddr == `IPVU_OFS_PRIO_LO)
            rdVal[7:0] = prioLo_r;
        else if (paddr == `IPVU_OFS_PRIO_HI)
            rdVal[7:0] = prioHi_r;
        else if (paddr == `IPVU_OFS_CTRL)
            rdVal[7:0] = ctrl_r;
        else if (paddr == `IPVU_OFS_FLAGS)
            rdVal[13:0] = {converterDoneFlag, timer2OvfFlag, uartTxDoneFlag,
                           uartRxDoneFlag, timer1OvfFlag, timer0OvfFlag,
                           extFlag_r};
        else if (paddr == `IPVU_OFS_STATUS)
            rdVal[4:0] = {vecCallBusy, levelInProgress};
        else
            rdHit = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
            enA_r    <= `IPVU_RST_BYTE;
            enB_r    <= `IPVU_RST_BYTE;
            prioLo_r <= `IPVU_RST_BYTE;
            prioHi_r <= `IPVU_RST_BYTE;
            ctrl_r   <= `IPVU_RST_BYTE;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~rdHit;
            if (psel && penable && !pready && !pwrite)
                prdata <= rdVal;
            if (wrStb)
            begin
                if (paddr == `IPVU_OFS_ENA)
                    enA_r <= pwdata[7:0];
                else if (paddr == `IPVU_OFS_ENB)
                    enB_r <= pwdata[7:0];
                else if (paddr == `IPVU_OFS_PRIO_LO)
                    prioLo_r <= pwdata[7:0];
                else if (paddr == `IPVU_OFS_PRIO_HI)
                    prioHi_r <= pwdata[7:0];
                else if (paddr == `IPVU_OFS_CTRL)
                    ctrl_r <= pwdata[7:0];
            end
        end
    end
endmodule
`default_nettype wire

/* ipvu_defs.vh */
// Purpose: Constants for the interrupt poll and vector unit.
// Assumes: One ref_clk period per oscillator period, 12 per machine cycle.
// Notes:   Included by bare name from each design file.
//
// Functional notes
// - Capture request flags at state5_phase2; evaluate them in the next machine cycle.
// - No vector call while an equal or higher level routine is in progress.
// - Vector call only in the last cycle of the executing instruction.
// - After an interrupt exit or enable/priority access, one more instruction first.
// - Blocked requests are forgotten; every polling cycle starts fresh.
// - Higher level arriving during a call is vectored before the lower routine runs.
// - Serial, timer-2 and converter flags are never cleared on vectoring.
// - Clear ext0/ext1 flags only in edge mode; always clear ext2 to ext6.
// - Call pushes the program counter without status word, then loads the vector.
// - Fixed vector address per source, ext2 to ext6 spaced eight apart.
// - Interrupt exit clears the current level; plain exit leaves it marked.
// - Ext0/ext1: select 0 is low-level, select 1 is high-then-low sample.
// - Ext2/ext3: select 0 falling edge, select 1 rising edge.
// - Ext4, ext5 and ext6 set their flags on rising edges only.
// - Timer-2 trigger flag set on a falling pin edge while enabled.
// - Vector call lasts two machine cycles; at least three cycles to service.
// - Extra blocking is at most three or five cycles; response under nine.
// - Two-bit priority per group from both priority registers, 3 highest.
`ifndef IPVU_DEFS_VH
`define IPVU_DEFS_VH

`define IPVU_MC_LAST      4'hb
`define IPVU_PIN_SAMPLE   4'h8
`define IPVU_STATE5_PH2   4'h9

`define IPVU_OFS_ENA      8'h00
`define IPVU_OFS_ENB      8'h04
`define IPVU_OFS_PRIO_LO  8'h08
`define IPVU_OFS_PRIO_HI  8'h0c
`define IPVU_OFS_CTRL     8'h10
`define IPVU_OFS_FLAGS    8'h14
`define IPVU_OFS_STATUS   8'h18

`define IPVU_RST_BYTE     8'h00
`define IPVU_GLOBAL_EN    7
`define IPVU_CTRL_EXT0_EDGE 0
`define IPVU_CTRL_EXT1_EDGE 1
`define IPVU_CTRL_EXT2_RISE 2
`define IPVU_CTRL_EXT3_RISE 3
`define IPVU_CTRL_T2_TRIG   4

`define IPVU_NSRC         12
`define IPVU_NGRP         6
`define IPVU_NPIN         8
`define IPVU_SRC_ADC      4'h6
`define IPVU_VEC_BASE     16'h0003
`define IPVU_VEC_STEP     16'h0008
`define IPVU_VEC_ADC      16'h0043
`define IPVU_VEC_EXT2     16'h004b

`endif

/* ipvu_pin_sync.v */
// Purpose: Two-stage synchroniser for the external request pins.
// Assumes: Pins are asynchronous to ref_clk.
// Notes:   Only the second stage is visible outside.
`include "ipvu_defs.vh"
`default_nettype none
module ipvu_pin_sync (
    input  wire                     ref_clk,  // Clock.
    input  wire                     rst,      // Synchronous reset.
    input  wire [`IPVU_NPIN-1:0]    pinIn,    // Raw pins.
    output reg  [`IPVU_NPIN-1:0]    pinOut_r  // Synchronised pins.
);
    reg [`IPVU_NPIN-1:0] stage1_r;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            stage1_r <= {`IPVU_NPIN{1'b0}};
            pinOut_r <= {`IPVU_NPIN{1'b0}};
        end
        else
        begin
            stage1_r <= pinIn;
            pinOut_r <= stage1_r;
        end
    end
endmodule
`default_nettype wire

/* ipvu_unit_asserts.sv */
// Purpose: Concurrent checks on the poll and vector outputs.
// Assumes: 12 clocks per machine cycle and 24 per vector call.
// Notes:   Bound to every ipvu_unit below.
`default_nettype none
module ipvu_unit_asserts (
    input wire logic        ref_clk,         // Clock.
    input wire logic        rst,             // Reset.
    input wire logic        mcStart,         // Cycle start.
    input wire logic        vecCallStart,    // Call start.
    input wire logic        vecCallBusy,     // Call busy.
    input wire logic [15:0] vecAddr,         // Vector.
    input wire logic [1:0]  timerFlagClr,    // Timer clears.
    input wire logic [3:0]  levelInProgress, // Levels.
    input wire logic        instrFinalCycle, // Final cycle.
    input wire logic        instrBlockNext,  // Blocking instruction.
    input wire logic        intExitExec      // Exit pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] callCnt_r;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ====================
    // Call counter and checks
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            callCnt_r <= 5'h00;
        else if (vecCallStart)
            callCnt_r <= 5'h01;
        else if (callCnt_r != 5'h00 && callCnt_r < 5'h17)
            callCnt_r <= callCnt_r + 5'h01;
        else
            callCnt_r <= 5'h00;
    end
    sequence quietEleven;
        !mcStart [*8] ##1 !mcStart [*3];
    endsequence
    mc_period_a: assert property (mcStart |=> quietEleven ##1 mcStart)
        else $error("Machine cycle not 12 clocks.");
    call_align_a: assert property (vecCallStart |-> mcStart)
        else $error("Call not at machine cycle start.");
    call_final_a: assert property (vecCallStart && !$past(vecCallBusy) |->
        $past(instrFinalCycle) && !$past(instrBlockNext))
        else $error("Call outside a final unblocked cycle.");
    busy_hold_a: assert property (callCnt_r != 5'h00 |-> vecCallBusy && !vecCallStart)
        else $error("Call shorter than two machine cycles.");
    busy_end_a: assert property (callCnt_r == 5'h00 && !vecCallStart |-> !vecCallBusy)
        else $error("Call longer than two machine cycles.");
    level_rise_a: assert property (vecCallStart |-> levelInProgress > $past(levelInProgress))
        else $error("Call not above levels in progress.");
    vector_set_a: assert property (vecCallStart |-> vecAddr[2:0] == 3'h3 &&
        (vecAddr <= 16'h002b || vecAddr inside {[16'h0043:16'h006b]}))
        else $error("Vector outside the table.");
    vector_hold_a: assert property (!vecCallStart && !$past(rst) |-> $stable(vecAddr))
        else $error("Vector changed without a call.");
    timer_clear_a: assert property (timerFlagClr != 2'h0 |-> vecCallStart &&
        (timerFlagClr == 2'h1 ? vecAddr == 16'h000b : timerFlagClr == 2'h2 && vecAddr == 16'h001b))
        else $error("Flag clear without matching call.");
    exit_level_a: assert property (intExitExec && levelInProgress != 4'h0 |=>
        vecCallStart || levelInProgress < $past(levelInProgress))
        else $error("Exit left its level marked.");
endmodule
bind ipvu_unit ipvu_unit_asserts i_ipvu_unit_asserts (.ref_clk, .rst, .mcStart, .vecCallStart, .vecCallBusy, .vecAddr,
    .timerFlagClr, .levelInProgress, .instrFinalCycle, .instrBlockNext, .intExitExec);
`default_nettype wire

/* ipvu_core_model.sv */
// Purpose: Instruction sequencing core beside the poll and vector unit.
// Assumes: Each instruction lasts instrLen machine cycles (1 or 2).
// Notes:   An exit request makes the next instruction an interrupt exit.
`default_nettype none
module ipvu_core_model (
    input  wire logic       ref_clk,         // Clock.
    input  wire logic       rst,             // Reset.
    input  wire logic       mcStart,         // Machine cycle start.
    input  wire logic       vecCallBusy,     // Call in progress.
    input  wire logic [1:0] instrLen,        // Cycles per instruction.
    input  wire logic       exitCmd,         // Exit request pulse.
    output wire logic       instrFinalCycle, // Last instruction cycle.
    output wire logic       instrBlockNext,  // Exit running.
    output var  logic       intExitExec      // Exit done pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_r;
    logic       exit_r;
    logic       pend_r;
    logic       endPrev;
    // ====================
    // Sequencing
    // Position 3 marks the call cycles, after which a new instruction starts.
    assign endPrev = pos_r == instrLen - 2'h1 || pos_r == 2'h3;
    assign instrFinalCycle = !vecCallBusy && pos_r == instrLen - 2'h1;
    assign instrBlockNext = !vecCallBusy && exit_r;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pos_r <= 2'h0;
            exit_r <= 1'b0;
            pend_r <= 1'b0;
            intExitExec <= 1'b0;
        end
        else
        begin
            intExitExec <= mcStart && exit_r && pos_r == instrLen - 2'h1;
            pend_r <= exitCmd | (pend_r & !(mcStart && !vecCallBusy && endPrev));
            if (mcStart)
                pos_r <= vecCallBusy ? 2'h3 : endPrev ? 2'h0 : pos_r + 2'h1;
            if (mcStart && !vecCallBusy && endPrev)
                exit_r <= pend_r;
        end
    end
endmodule
`default_nettype wire

/* test_ipvu_unit.sv */
// Purpose: Self-checking bench for the poll and vector unit.
// Assumes: Pins are held for whole machine cycles.
// Notes:   Registers are reached over APB.
`default_nettype none
module test_ipvu_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, t2Pin = 1'b1;
    logic        exitCmd = 1'b0, pready, pslverr, mcStart, vecCallStart, vecCallBusy, fin, blk, ex, errBit;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [6:0]  extPin = 7'h07;
    logic [5:0]  periph = 6'h00;
    logic [15:0] vecAddr;
    logic [1:0]  timerFlagClr, instrLen = 2'h2;
    logic [3:0]  levelInProgress;
    int          fail_count = 0, comparisons = 0, s, c;
    int          code [12] = '{0, 8, 1, 9, 10, 12, 13, 2, 3, 4, 5, 6};
    always #12.5 ref_clk = ~ref_clk;
    ipvu_unit i_ipvu_unit (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .extReqPin(extPin), .timer2TriggerPin(t2Pin), .timer0OvfFlag(periph[0]), .timer1OvfFlag(periph[1]),
        .uartRxDoneFlag(periph[2]), .uartTxDoneFlag(periph[3]), .timer2OvfFlag(periph[4]),
        .converterDoneFlag(periph[5]), .instrFinalCycle(fin), .instrBlockNext(blk), .intExitExec(ex),
        .mcStart, .vecCallStart, .vecCallBusy, .vecAddr, .timerFlagClr, .levelInProgress);
    ipvu_core_model i_ipvu_core_model (.ref_clk, .rst, .mcStart, .vecCallBusy, .instrLen, .exitCmd,
        .instrFinalCycle(fin), .instrBlockNext(blk), .intExitExec(ex));
    // ====================
    // Tasks
    task test_done;
        $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        c = 0;
        do
        begin
            @(posedge ref_clk);
            c++;
        end
        while (pready !== 1'b1 && c < 20);
        if (pready !== 1'b1)
        begin
            chk("pready", 1, pready);
            test_done;
        end
        rdat = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits up to lim clocks for a call; c ends as the clocks waited.
    task waitCall(input int lim, input logic want);
        c = 0;
        do
        begin
            @(posedge ref_clk);
            c++;
        end
        while (vecCallStart !== 1'b1 && c < lim);
        chk("call seen", want, vecCallStart);
        if (want && vecCallStart !== 1'b1)
            test_done;
    endtask
    task exitOnce(input logic [3:0] lvl);
        @(posedge ref_clk);
        exitCmd <= 1'b1;
        @(posedge ref_clk);
        exitCmd <= 1'b0;
        c = 0;
        while (levelInProgress !== lvl && c < 200)
        begin
            @(posedge ref_clk);
            c++;
        end
        chk("level after exit", lvl, levelInProgress);
    endtask
    // ====================
    // Sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        for (s = 0; s < 8; s++)
        begin
            apb(1'b0, 8'(4 * s), 32'h0);
            chk("reset value", 32'h0, rdat);
            chk("slave error", s == 7, errBit);
        end
        apb(1'b1, 8'h00, 32'h0000_00bf);
        apb(1'b1, 8'h04, 32'h0000_003f);
        apb(1'b1, 8'h10, 32'h0000_000b);
        for (s = 0; s < 12; s++)
        begin
            if (code[s] < 8)
                extPin[code[s]] <= ~extPin[code[s]];
            else
                periph[code[s] - 8] <= 1'b1;
            waitCall(400, 1'b1);
            chk("vector", s < 6 ? 16'h0003 + 16'(8 * s) : 16'h0043 + 16'(8 * s - 48), vecAddr);
            chk("level", 32'h1, levelInProgress);
            chk("timer clear", code[s] == 8 ? 1 : code[s] == 9 ? 2 : 0, timerFlagClr);
            extPin <= 7'h07;
            periph <= 6'h00;
            apb(1'b0, 8'h14, 32'h0);
            chk("pin flags", 32'h0, rdat[6:0]);
            exitOnce(4'h0);
        end
        t2Pin <= 1'b0;
        waitCall(60, 1'b0);
        t2Pin <= 1'b1;
        apb(1'b1, 8'h10, 32'h0000_001b);
        waitCall(24, 1'b0);
        t2Pin <= 1'b0;
        waitCall(400, 1'b1);
        chk("trigger vector", 16'h002b, vecAddr);
        apb(1'b0, 8'h14, 32'h0);
        chk("trigger flag kept", 1, rdat[7]);
        apb(1'b1, 8'h14, 32'h0000_0080);
        exitOnce(4'h0);
        apb(1'b1, 8'h08, 32'h0000_0002);
        apb(1'b1, 8'h0c, 32'h0000_0002);
        apb(1'b1, 8'h10, 32'h0000_000a);
        extPin[1] <= 1'b0;
        waitCall(400, 1'b1);
        periph[0] <= 1'b1;
        extPin[1] <= 1'b1;
        waitCall(30, 1'b1);
        chk("nested gap", 24, c);
        chk("nested vector", 16'h000b, vecAddr);
        chk("nested levels", 32'h9, levelInProgress);
        periph[0] <= 1'b0;
        extPin[0] <= 1'b0;
        waitCall(72, 1'b0);
        extPin[0] <= 1'b1;
        exitOnce(4'h1);
        exitOnce(4'h0);
        waitCall(72, 1'b0);
        extPin[0] <= 1'b0;
        waitCall(400, 1'b1);
        chk("level vector", 16'h0003, vecAddr);
        apb(1'b0, 8'h14, 32'h0);
        chk("level flag kept", 1, rdat[0]);
        extPin[0] <= 1'b1;
        exitOnce(4'h0);
        waitCall(72, 1'b0);
        test_done;
    end
endmodule
`default_nettype wire
